// ===== pkg/iapfc_pkg.sv
// Purpose: Shared constants and types for the flash programming sequencer
// Assumes: 8-bit register port, 13-bit flash word address, 16-bit words
// Notes:   Register offsets are indices on the plain register port

package iapfc_pkg;

    // Register port geometry
    localparam int RA_W = 4;
    localparam int DW   = 8;

    // Register offsets
    localparam logic [3:0] A_ADDR_LO = 4'h0;
    localparam logic [3:0] A_ADDR_HI = 4'h1;
    localparam logic [3:0] A_D0L     = 4'h2;
    localparam logic [3:0] A_D0H     = 4'h3;
    localparam logic [3:0] A_D1L     = 4'h4;
    localparam logic [3:0] A_D1H     = 4'h5;
    localparam logic [3:0] A_D2L     = 4'h6;
    localparam logic [3:0] A_D2H     = 4'h7;
    localparam logic [3:0] A_D3L     = 4'h8;
    localparam logic [3:0] A_D3H     = 4'h9;
    localparam logic [3:0] A_CTRL    = 4'ha;
    localparam logic [3:0] A_RSTKEY  = 4'hb;
    localparam logic [3:0] A_BUFCLR  = 4'hc;

    // Control and buffer clear register field positions
    localparam int B_EN    = 7;
    localparam int B_MODE  = 4;
    localparam int B_TRIG  = 3;
    localparam int B_WINIT = 2;
    localparam int B_RDEN  = 1;
    localparam int B_RINIT = 0;
    localparam int B_BCLR  = 0;

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;

    // Unlock key, second to fourth pair
    localparam logic [7:0] KEY_D1L = 8'h00;
    localparam logic [7:0] KEY_D2L = 8'h0d;
    localparam logic [7:0] KEY_D3L = 8'hc3;
    localparam logic [7:0] KEY_D1H = 8'h04;
    localparam logic [7:0] KEY_D2H = 8'h09;
    localparam logic [7:0] KEY_D3H = 8'h40;
    localparam logic [7:0] CHIP_RESET_KEY = 8'h55;

    // Flash geometry
    localparam int         FA_W     = 13;
    localparam int         OFS_W    = 5;
    localparam int         PAGE_WDS = 32;
    localparam logic [4:0] LAST_OFS = 5'h1f;

    // Operation mode field codes
    typedef enum logic [2:0] {
        MODE_WRITE  = 3'h0,
        MODE_ERASE  = 3'h1,
        MODE_READ   = 3'h3,
        MODE_UNLOCK = 3'h6
    } iapfc_mode_e;

    // Array operation codes
    typedef enum logic [1:0] {
        FOP_READ  = 2'h0,
        FOP_WRITE = 2'h1,
        FOP_ERASE = 2'h2
    } iapfc_fop_e;

    // Register port request
    typedef struct packed {
        logic             wr;
        logic             rd;
        logic [RA_W-1:0]  addr;
        logic [DW-1:0]    wdata;
    } iapfc_bus_s;

    // Request towards the flash array
    typedef struct packed {
        logic             req;
        iapfc_fop_e       op;
        logic [FA_W-1:0]  addr;
        logic [15:0]      wdata;
    } iapfc_flash_req_s;

endpackage : iapfc_pkg

// ===== rtl/iapfc_top.sv
// Purpose: Sequencer for in-application erase, write and read of flash
// Assumes: Flash array answers each request with a one-cycle ack
// Notes:   CPU halt is raised for the whole of any accepted operation

`timescale 1ns/10ps
`default_nettype none

module iapfc_top #(
    parameter int UNLOCK_CYCLES = 256       // Unlock window in clocks
) (
    // Clock and reset
    input  wire logic                         sys_clk,
    input  wire logic                         rst_n,
    // Register port
    input  wire iapfc_pkg::iapfc_bus_s        bus_i,
    output logic [7:0]                        bus_rdata,
    // Flash array
    output var  iapfc_pkg::iapfc_flash_req_s  flash_o,
    input  wire logic                         flash_ack,
    input  wire logic [15:0]                  flash_rdata,
    // System
    output logic                              cpu_halt,
    output logic                              chip_reset
);
    import iapfc_pkg::*;

    // Sequencer states, Gray along the scan path except scan to finish
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SCAN   = 3'b001,
        ST_WAIT   = 3'b011,
        ST_FINISH = 3'b010,
        ST_RDWAIT = 3'b110
    } iapfc_state_e;

    // Write strobe decode for one offset
    function automatic logic wr_hit(input iapfc_bus_s b,
                                    input logic [3:0] a);
        return b.wr && (b.addr == a);
    endfunction : wr_hit

    // Control fields
    logic              en_q;                // Erase/write enabled status
    logic [2:0]        mode_q;              // Operation mode field
    logic              trig_q;              // Unlock trigger
    logic              winit_q;             // Write initiate
    logic              rden_q;              // Read enable
    logic              rinit_q;             // Read initiate
    logic              bclr_q;              // Buffer clear
    // Address and data registers
    logic [FA_W-1:0]   addr_q;              // Flash word address
    logic [7:0]        d0l_q, d0h_q;        // First data pair
    logic [7:0]        d1l_q, d1h_q;        // Key pair two
    logic [7:0]        d2l_q, d2h_q;        // Key pair three
    logic [7:0]        d3l_q, d3h_q;        // Key pair four
    logic [7:0]        rstkey_q;            // Chip reset key
    // Write buffer
    logic [15:0]       wbuf_q [PAGE_WDS];   // Buffered words
    logic [PAGE_WDS-1:0] tag_q;             // Tagged offsets
    // Unlock timer
    logic [$clog2(UNLOCK_CYCLES+1)-1:0] tmr_q;
    // Sequencer
    iapfc_state_e      state_q;
    logic [OFS_W-1:0]  idx_q;               // Scan offset
    logic              is_wr_q;             // Running op is a write
    logic              is_rd_q;             // Running op is a read
    // Output flops
    logic [7:0]        rdata_q;
    iapfc_flash_req_s  freq_q;
    logic              halt_q;
    logic              crst_q;

    // Decoded strobes and events
    logic ctrl_wr, d0h_wr, expire, key_ok, unlock_ok;
    logic start_ew, start_rd, rej_w, rej_r, both_init;
    logic fin, clr_buf;

    assign ctrl_wr = wr_hit(bus_i, A_CTRL);
    assign d0h_wr  = wr_hit(bus_i, A_D0H);

    // Expiry on the last timer count
    assign expire = trig_q &&
        (tmr_q == ($bits(tmr_q))'(UNLOCK_CYCLES - 1));

    // Key judged from register contents before expiry
    assign key_ok = (d1l_q == KEY_D1L) && (d2l_q == KEY_D2L) &&
                    (d3l_q == KEY_D3L) && (d1h_q == KEY_D1H) &&
                    (d2h_q == KEY_D2H) && (d3h_q == KEY_D3H);
    assign unlock_ok = expire && key_ok &&
                       (mode_q == MODE_UNLOCK);

    // Start decisions, only taken from idle
    assign both_init = winit_q && rinit_q;
    assign start_ew  = (state_q == ST_IDLE) && winit_q && !both_init &&
                       en_q && ((mode_q == MODE_WRITE) ||
                                (mode_q == MODE_ERASE));
    assign rej_w     = (state_q == ST_IDLE) && winit_q && !start_ew;
    assign start_rd  = (state_q == ST_IDLE) && rinit_q && !both_init &&
                       rden_q && (mode_q == MODE_READ);
    assign rej_r     = (state_q == ST_IDLE) && rinit_q && !start_rd;

    // Operation end and buffer clearing
    assign fin     = (state_q == ST_FINISH);
    assign clr_buf = bclr_q || (fin && is_wr_q);

    // Enabled status: hardware sets, software can only clear
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            en_q <= 1'b0;
        end else if (unlock_ok) begin
            en_q <= 1'b1;
        end else if (ctrl_wr && !bus_i.wdata[B_EN]) begin
            en_q <= 1'b0;
        end
    end

    // Mode field and read enable are plain storage
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mode_q <= MODE_WRITE;
            rden_q <= 1'b0;
        end else if (ctrl_wr) begin
            mode_q <= bus_i.wdata[B_MODE +: 3];
            rden_q <= bus_i.wdata[B_RDEN];
        end
    end

    // Unlock trigger: set by software, cleared at expiry
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            trig_q <= 1'b0;
        end else if (ctrl_wr && bus_i.wdata[B_TRIG]) begin
            trig_q <= 1'b1;
        end else if (expire) begin
            trig_q <= 1'b0;
        end
    end

    // Unlock timer restarts only on a fresh trigger
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tmr_q <= '0;
        end else if (!trig_q) begin
            tmr_q <= '0;
        end else if (!expire) begin
            tmr_q <= tmr_q + 1'b1;
        end
    end

    // Initiate bits: software sets, hardware clears at end or refusal
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            winit_q <= 1'b0;
            rinit_q <= 1'b0;
        end else begin
            // Set wins over a same-cycle hardware clear
            if (ctrl_wr && bus_i.wdata[B_WINIT]) begin
                winit_q <= 1'b1;
            end else if (rej_w || (fin && !is_rd_q)) begin
                winit_q <= 1'b0;
            end
            if (ctrl_wr && bus_i.wdata[B_RINIT]) begin
                rinit_q <= 1'b1;
            end else if (rej_r || (fin && is_rd_q)) begin
                rinit_q <= 1'b0;
            end
        end
    end

    // Buffer clear bit: one clearing cycle then back to zero
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bclr_q <= 1'b0;
        end else if (wr_hit(bus_i, A_BUFCLR) && bus_i.wdata[B_BCLR]) begin
            bclr_q <= 1'b1;
        end else begin
            bclr_q <= 1'b0;
        end
    end

    // Address pair: software loads, high data writes advance in page
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            addr_q <= '0;
        end else if (wr_hit(bus_i, A_ADDR_LO)) begin
            addr_q[7:0] <= bus_i.wdata;
        end else if (wr_hit(bus_i, A_ADDR_HI)) begin
            addr_q[FA_W-1:8] <= bus_i.wdata[FA_W-9:0];
        end else if (d0h_wr && (addr_q[OFS_W-1:0] != LAST_OFS)) begin
            // Saturate at the last word of the page
            addr_q <= addr_q + 1'b1;
        end
    end

    // Data and key registers; a finished read lands in the first pair
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            d0l_q <= RST_BYTE;
            d0h_q <= RST_BYTE;
            d1l_q <= RST_BYTE;
            d1h_q <= RST_BYTE;
            d2l_q <= RST_BYTE;
            d2h_q <= RST_BYTE;
            d3l_q <= RST_BYTE;
            d3h_q <= RST_BYTE;
        end else if (state_q == ST_RDWAIT && flash_ack) begin
            d0l_q <= flash_rdata[7:0];
            d0h_q <= flash_rdata[15:8];
        end else if (bus_i.wr) begin
            case (bus_i.addr)
                A_D0L:   d0l_q <= bus_i.wdata;
                A_D0H:   d0h_q <= bus_i.wdata;
                A_D1L:   d1l_q <= bus_i.wdata;
                A_D1H:   d1h_q <= bus_i.wdata;
                A_D2L:   d2l_q <= bus_i.wdata;
                A_D2H:   d2h_q <= bus_i.wdata;
                A_D3L:   d3l_q <= bus_i.wdata;
                A_D3H:   d3h_q <= bus_i.wdata;
                default: ;                                    // Others elsewhere
            endcase
        end
    end

    // Write buffer and tags; clearing beats loading
    always_ff @(posedge sys_clk) begin
        if (!rst_n || clr_buf) begin
            tag_q <= '0;
            for (int i = 0; i < PAGE_WDS; i++) begin
                wbuf_q[i] <= 16'h0000;
            end
        end else if (d0h_wr && en_q) begin
            // Whole word taken from the pair as the high byte arrives
            wbuf_q[addr_q[OFS_W-1:0]] <= {bus_i.wdata, d0l_q};
            tag_q[addr_q[OFS_W-1:0]]  <= 1'b1;
        end
    end

    // Chip reset key: a single pulse per matching write
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rstkey_q <= RST_BYTE;
            crst_q   <= 1'b0;
        end else begin
            crst_q <= wr_hit(bus_i, A_RSTKEY) &&
                      (bus_i.wdata == CHIP_RESET_KEY);
            if (wr_hit(bus_i, A_RSTKEY)) begin
                rstkey_q <= bus_i.wdata;
            end
        end
    end

    // Sequencer: walks tagged offsets of the page, or does one read
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            idx_q   <= '0;
            is_wr_q <= 1'b0;
            is_rd_q <= 1'b0;
            halt_q  <= 1'b0;
            freq_q  <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    idx_q <= '0;
                    if (start_ew) begin
                        is_wr_q <= (mode_q == MODE_WRITE);
                        is_rd_q <= 1'b0;
                        halt_q  <= 1'b1;
                        state_q <= ST_SCAN;
                    end else if (start_rd) begin
                        is_wr_q     <= 1'b0;
                        is_rd_q     <= 1'b1;
                        halt_q      <= 1'b1;
                        freq_q.req  <= 1'b1;
                        freq_q.op   <= FOP_READ;
                        freq_q.addr <= addr_q;
                        state_q     <= ST_RDWAIT;
                    end
                end
                ST_SCAN: begin
                    if (tag_q[idx_q]) begin
                        // Only tagged words reach the array
                        freq_q.req   <= 1'b1;
                        freq_q.op    <= is_wr_q ? FOP_WRITE : FOP_ERASE;
                        freq_q.addr  <= {addr_q[FA_W-1:OFS_W], idx_q};
                        freq_q.wdata <= wbuf_q[idx_q];
                        state_q      <= ST_WAIT;
                    end else if (idx_q == LAST_OFS) begin
                        state_q <= ST_FINISH;
                    end else begin
                        idx_q <= idx_q + 1'b1;
                    end
                end
                ST_WAIT: begin
                    // Request held until the array answers
                    if (flash_ack) begin
                        freq_q.req <= 1'b0;
                        if (idx_q == LAST_OFS) begin
                            state_q <= ST_FINISH;
                        end else begin
                            idx_q   <= idx_q + 1'b1;
                            state_q <= ST_SCAN;
                        end
                    end
                end
                ST_RDWAIT: begin
                    if (flash_ack) begin
                        freq_q.req <= 1'b0;
                        state_q    <= ST_FINISH;
                    end
                end
                ST_FINISH: begin
                    halt_q  <= 1'b0;
                    state_q <= ST_IDLE;
                end
                default: begin
                    freq_q  <= '0;
                    halt_q  <= 1'b0;
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !bus_i.rd) begin
            rdata_q <= 8'h00;
        end else begin
            case (bus_i.addr)
                A_ADDR_LO: rdata_q <= addr_q[7:0];
                A_ADDR_HI: rdata_q <= {3'h0, addr_q[FA_W-1:8]};
                A_D0L:     rdata_q <= d0l_q;
                A_D0H:     rdata_q <= d0h_q;
                A_D1L:     rdata_q <= d1l_q;
                A_D1H:     rdata_q <= d1h_q;
                A_D2L:     rdata_q <= d2l_q;
                A_D2H:     rdata_q <= d2h_q;
                A_D3L:     rdata_q <= d3l_q;
                A_D3H:     rdata_q <= d3h_q;
                A_CTRL:    rdata_q <= {en_q, mode_q, trig_q,
                                       winit_q, rden_q, rinit_q};
                A_RSTKEY:  rdata_q <= rstkey_q;
                A_BUFCLR:  rdata_q <= {7'h00, bclr_q};
                default:   rdata_q <= 8'h00;                  // Unmapped
            endcase
        end
    end

    // Outputs straight from flops
    assign bus_rdata  = rdata_q;
    assign flash_o    = freq_q;
    assign cpu_halt   = halt_q;
    assign chip_reset = crst_q;

endmodule : iapfc_top

`default_nettype wire

// ===== verif/iapfc_monitor.sv
// Purpose: Port-level checks for the flash programming sequencer
// Assumes: Bound to iapfc_top, one clock domain, synchronous reset
// Notes:   Watches only the top-level ports of the sequencer
`timescale 1ns/10ps
`default_nettype none

module iapfc_monitor
    import iapfc_pkg::*;
#(
    parameter int UNLOCK_CYCLES = 256  // Handed on, not used in checks
) (
    // Clock and reset
    input wire logic                        sys_clk,
    input wire logic                        rst_n,
    // Register port
    input wire iapfc_pkg::iapfc_bus_s       bus_i,
    input wire logic [7:0]                  bus_rdata,
    // Flash array and system
    input wire iapfc_pkg::iapfc_flash_req_s flash_o,
    input wire logic                        flash_ack,
    input wire logic [15:0]                 flash_rdata,
    input wire logic                        cpu_halt,
    input wire logic                        chip_reset
);
    import iapfc_pkg::*;

    // All checks share the one clock and its reset
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_key_resets_chip:
        assert property (bus_i.wr && bus_i.addr == A_RSTKEY
            && bus_i.wdata == CHIP_RESET_KEY |=> chip_reset)
        else $error("reset key write gave no chip reset");
    a_no_stray_reset:
        assert property (!(bus_i.wr && bus_i.addr == A_RSTKEY
            && bus_i.wdata == CHIP_RESET_KEY) |=> !chip_reset)
        else $error("chip reset without key write");
    a_enable_not_set:
        assert property (bus_i.wr && bus_i.addr == A_CTRL
            && !bus_i.wdata[B_EN] ##1 bus_i.rd && bus_i.addr == A_CTRL
            |=> !bus_rdata[B_EN])
        else $error("enabled status survived a zero write");
    a_clear_upper_zero:
        assert property (bus_i.rd && bus_i.addr == A_BUFCLR
            |=> bus_rdata[7:1] == 7'h00)
        else $error("buffer clear upper bits not zero");
    a_clear_bit_shows:
        assert property (bus_i.wr && bus_i.addr == A_BUFCLR
            && bus_i.wdata[B_BCLR] ##1 bus_i.rd && bus_i.addr == A_BUFCLR
            |=> bus_rdata[B_BCLR])
        else $error("buffer clear bit not seen set");
    a_clear_bit_drops:
        assert property (bus_i.wr && bus_i.addr == A_BUFCLR
            && bus_i.wdata[B_BCLR] ##1 !bus_i.wr ##1
            bus_i.rd && bus_i.addr == A_BUFCLR |=> !bus_rdata[B_BCLR])
        else $error("buffer clear bit did not self clear");
    a_req_needs_halt:
        assert property (flash_o.req |-> cpu_halt)
        else $error("flash request while cpu runs");
    a_ack_ends_req:
        assert property (flash_o.req && flash_ack |=> !flash_o.req)
        else $error("request stayed after ack");
    a_req_holds:
        assert property (flash_o.req && !flash_ack
            |=> flash_o.req && $stable(flash_o.addr))
        else $error("request dropped or moved before ack");
    a_op_code_legal:
        assert property (flash_o.req |-> flash_o.op inside
            {FOP_READ, FOP_WRITE, FOP_ERASE})
        else $error("illegal flash operation code");

endmodule : iapfc_monitor

bind iapfc_top iapfc_monitor #(.UNLOCK_CYCLES(UNLOCK_CYCLES)) i_iapfc_monitor (
    .sys_clk(sys_clk), .rst_n(rst_n), .bus_i(bus_i),
    .bus_rdata(bus_rdata), .flash_o(flash_o), .flash_ack(flash_ack),
    .flash_rdata(flash_rdata), .cpu_halt(cpu_halt),
    .chip_reset(chip_reset));
`default_nettype wire

// ===== verif/tb_top.sv
// Purpose: Self-checking bench for the flash programming sequencer
// Assumes: Short unlock window; the bench plays the flash array
// Notes:   Seeded random data mixed with fixed corner cases
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    import iapfc_pkg::*;

    localparam int UNL = 8;             // Shortened unlock window
    logic             sys_clk;          // 20 MHz clock
    logic             rst_n;            // Synchronous reset
    iapfc_bus_s       bus_i;            // Register port request
    logic [7:0]       bus_rdata;        // Register read data
    iapfc_flash_req_s flash_o;          // Array request
    logic             flash_ack;        // Array done
    logic [15:0]      flash_rdata;      // Array read word
    logic             cpu_halt;         // CPU stall
    logic             chip_reset;       // Whole-chip reset pulse
    int               fail_count;       // Mismatches
    int               samples_checked;  // Comparisons
    int               cycles;           // Hang guard
    int               dly;              // Array answer delay
    logic [15:0]      rd_word;          // Last word handed back
    iapfc_flash_req_s log_q[$];         // Requests taken by the array
    logic [15:0]      w[4];             // Words loaded
    logic [12:0]      ra;               // Read address
    logic [7:0]       page;             // Page under test
    logic             seen;             // Halt observed

    iapfc_top #(.UNLOCK_CYCLES(UNL)) i_iapfc_top (
        .sys_clk(sys_clk), .rst_n(rst_n), .bus_i(bus_i),
        .bus_rdata(bus_rdata), .flash_o(flash_o), .flash_ack(flash_ack),
        .flash_rdata(flash_rdata), .cpu_halt(cpu_halt),
        .chip_reset(chip_reset));

    // Clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Array stand-in: slow or prompt ack; data inverted when not valid
    always @(posedge sys_clk) begin
        if (flash_o.req && !flash_ack && dly == 0) begin
            rd_word = 16'($urandom);
            flash_ack   <= 1'b1;
            flash_rdata <= rd_word;
            log_q.push_back(flash_o);
            dly = $urandom_range(3);
        end else begin
            flash_ack   <= 1'b0;
            flash_rdata <= ~rd_word;
            if (flash_o.req && !flash_ack && dly > 0) dly--;
        end
    end

    // Hang guard, far above the expected run length
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            $display("FAIL t=%0t run did not finish", $time);
            end_of_test();
        end
    end

    task automatic chk8(input logic [7:0] g, input logic [7:0] e,
                        input string s);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("FAIL t=%0t %s got %h exp %h", $time, s, g, e);
        end
    endtask : chk8

    // Request check; write data only matters for word writes
    task automatic chk_req(input int i, input iapfc_fop_e op,
                           input logic [12:0] a, input logic [15:0] d);
        samples_checked++;
        if (i >= log_q.size() || log_q[i].op !== op || log_q[i].addr !== a
            || (op == FOP_WRITE && log_q[i].wdata !== d)) begin
            fail_count++;
            $display("FAIL t=%0t request %0d wrong", $time, i);
        end
    endtask : chk_req

    // Strobe is left up so back-to-back writes need no gap
    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        bus_i.wr    <= 1'b1;
        bus_i.rd    <= 1'b0;
        bus_i.addr  <= a;
        bus_i.wdata <= d;
        @(posedge sys_clk);
    endtask : bus_wr

    task automatic quiet(input int n);
        bus_i.wr <= 1'b0;
        bus_i.rd <= 1'b0;
        repeat (n) @(posedge sys_clk);
    endtask : quiet

    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e,
                          input string s);
        bus_i.wr   <= 1'b0;
        bus_i.rd   <= 1'b1;
        bus_i.addr <= a;
        @(posedge sys_clk);
        bus_i.rd <= 1'b0;
        @(negedge sys_clk);
        chk8(bus_rdata, e, s);
        @(posedge sys_clk);
    endtask : rd_chk

    // Unlock attempt; bad >= 0 corrupts one key byte
    task automatic unlock(input logic [2:0] m, input int bad);
        logic [7:0] k[6];
        k = '{KEY_D1L, KEY_D1H, KEY_D2L, KEY_D2H, KEY_D3L, KEY_D3H};
        if (bad >= 0) k[bad] = k[bad] ^ 8'(1 + $urandom_range(254));
        bus_wr(A_CTRL, {1'b0, m, 4'h8});
        for (int i = 0; i < 6; i++) bus_wr(A_D1L + 4'(i), k[i]);
        quiet(UNL + 2);
    endtask : unlock

    // Start an operation, log array traffic, wait for halt to end
    task automatic run_op(input logic [7:0] ctl, output logic h);
        h = 1'b0;
        log_q.delete();
        bus_wr(A_CTRL, ctl);
        quiet(1);
        for (int i = 0; i < 150 && !(h && !cpu_halt); i++) begin
            @(negedge sys_clk);
            if (cpu_halt === 1'b1) h = 1'b1;
        end
        @(posedge sys_clk);
    endtask : run_op

    task automatic load(input logic [7:0] al, input int n);
        bus_wr(A_ADDR_HI, {3'h0, page[7:3]});
        bus_wr(A_ADDR_LO, al);
        for (int i = 0; i < n; i++) begin
            w[i] = 16'($urandom);
            bus_wr(A_D0L, w[i][7:0]);
            bus_wr(A_D0H, w[i][15:8]);
        end
    endtask : load

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test

    initial begin
        rst_n = 1'b0;
        bus_i = '0;
        flash_ack = 1'b0;
        flash_rdata = 16'h0000;
        rd_word = 16'h0000;
        {fail_count, samples_checked, cycles, dly} = '0;
        void'($urandom(78));
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 16; a++) rd_chk(4'(a), 8'h00, "reset");
        for (int a = 9; a >= 0; a--) begin
            w[0][7:0] = 8'($urandom);
            bus_wr(4'(a), w[0][7:0]);
            rd_chk(4'(a), (a == 1) ? {3'h0, w[0][4:0]} : w[0][7:0], "rw");
        end
        $display("test registers done");
        bus_wr(A_CTRL, 8'h90);
        rd_chk(A_CTRL, 8'h10, "enable set by sw");
        bus_wr(A_BUFCLR, 8'hff);
        rd_chk(A_BUFCLR, 8'h01, "clear busy");
        bus_wr(A_BUFCLR, 8'h01);
        quiet(1);
        rd_chk(A_BUFCLR, 8'h00, "clear done");
        for (int i = 0; i < 2; i++) begin
            bus_wr(A_RSTKEY, i ? CHIP_RESET_KEY : 8'($urandom_range(84)));
            bus_i.wr <= 1'b0;
            @(negedge sys_clk);
            chk8(8'(chip_reset), 8'(i), "chip reset");
            @(posedge sys_clk);
        end
        $display("test control done");
        for (int m = 0; m < 8; m++) begin
            unlock(3'(m), (m == 6) ? $urandom_range(5) : -1);
            rd_chk(A_CTRL, {1'b0, 3'(m), 4'h0}, "locked");
        end
        unlock(3'h6, -1);
        rd_chk(A_CTRL, 8'he0, "unlocked");
        $display("test unlock done");
        page = 8'($urandom);
        load({page[2:0], 5'h1d}, 4);
        rd_chk(A_ADDR_LO, {page[2:0], 5'h1f}, "saturate");
        run_op(8'h94, seen);
        chk8(8'(log_q.size()), 8'h03, "erase count");
        for (int i = 0; i < 3; i++)
            chk_req(i, FOP_ERASE, {page, 5'h1d + 5'(i)}, 0);
        run_op(8'h84, seen);
        chk8(8'(seen), 8'h01, "halt");
        for (int i = 0; i < 3; i++)
            chk_req(i, FOP_WRITE, {page, 5'h1d + 5'(i)},
                    w[i == 2 ? 3 : i]);
        rd_chk(A_CTRL, 8'h80, "write done");
        run_op(8'h84, seen);
        chk8(8'(log_q.size()), 8'h00, "buffer kept");
        for (int m = 2; m < 8; m++) begin
            run_op({1'b1, 3'(m), 4'h4}, seen);
            chk8(8'(seen), 8'h00, "reserved ran");
        end
        load({page[2:0], 5'h00}, 1);
        bus_wr(A_BUFCLR, 8'h01);
        quiet(3);
        run_op(8'h84, seen);
        chk8(8'(log_q.size()), 8'h00, "clear missed");
        bus_wr(A_CTRL, 8'h00);
        rd_chk(A_CTRL, 8'h00, "enable cleared");
        run_op(8'h94, seen);
        chk8(8'(seen), 8'h00, "locked erase");
        $display("test program done");
        ra = 13'($urandom);
        bus_wr(A_ADDR_HI, {3'h0, ra[12:8]});
        bus_wr(A_ADDR_LO, ra[7:0]);
        run_op(8'h31, seen);
        chk8(8'(seen), 8'h00, "read disabled");
        run_op(8'h33, seen);
        chk_req(0, FOP_READ, ra, 0);
        rd_chk(A_D0L, rd_word[7:0], "read low");
        rd_chk(A_D0H, rd_word[15:8], "read high");
        rd_chk(A_CTRL, 8'h32, "read done");
        $display("test read done");
        end_of_test();
    end

endmodule : tb_top
`default_nettype wire
